/* verilog/hcs_pkg.sv */
`default_nettype none
package hcs_pkg;
  localparam int N_ENT = 16;
  localparam int IDX_W = 4;
  localparam int CFG_IDX_W = 5;
  localparam int N_CNT = 8;
  localparam int N_TMR = 8;
  localparam int SEL_W = 3;
  localparam int CNT_W = 32;
  localparam int TMR_W = 16;
  localparam int N_EVT = 8;
  localparam int SRC_W = N_EVT + N_TMR;
  localparam int N_PIN = 8;
  localparam int POL_W = 8;
  localparam int LEN_W = 11;
  localparam int LEN_LSB = 0;
  localparam int TOK_W = 4;
  localparam int TOK_LSB = 12;
  localparam logic [LEN_W-1:0] MAX_PKT_LEN = 11'h5C0;
  localparam logic [TOK_W-1:0] MAX_TOKENS = 4'h8;
  localparam logic [SRC_W-1:0] MASK_NONE = 16'h0000;
  localparam int CLK_HZ = 20000000;
  localparam int TICK_S = 1;
  localparam int TICK_CYC = TICK_S * CLK_HZ;
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ROLE_STATION,
    ROLE_AP,
    ROLE_P2P,
    ROLE_TAG
  } hcs_role_t;

  typedef enum logic [1:0] {
    PKT_TRX,
    PKT_UDP,
    PKT_TCP
  } hcs_pkt_t;

  typedef enum logic [3:0] {
    ACT_NOP,
    ACT_SET_ROLE,
    ACT_DEL_PROFILES,
    ACT_SET_POLICY,
    ACT_HW_IND,
    ACT_SEND_TRX,
    ACT_SEND_UDP,
    ACT_SEND_TCP,
    ACT_CNT_INC,
    ACT_CNT_SET,
    ACT_TMR_CTRL,
    ACT_SET_GPIO,
    ACT_HIBERNATE
  } hcs_act_t;
endpackage
`default_nettype wire

/* verilog/hcs_cnt_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface hcs_cnt_if;
  logic inc;
  logic set;
  logic [hcs_pkg::SEL_W-1:0] sel;
  logic [hcs_pkg::CNT_W-1:0] val;
  logic [hcs_pkg::CNT_W-1:0] cnt [hcs_pkg::N_CNT];
  modport ctrl (output inc, output set, output sel, output val, input cnt);
  modport bank (input inc, input set, input sel, input val, output cnt);
endinterface
`default_nettype wire

/* verilog/hcs_counters.sv */
`timescale 1ns/1ps
`default_nettype none
module hcs_counters (
  input wire logic mclk_i, // module clock
  input wire logic reset_i, // sync reset, active high
  input wire logic ce_i, // clock enable
  hcs_cnt_if.bank cif // counter commands and values
);
  logic [hcs_pkg::CNT_W-1:0] cnt_q [hcs_pkg::N_CNT];

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < hcs_pkg::N_CNT; i++)
        cnt_q[i] <= hcs_pkg::CNT_RST;
    end
    else if (ce_i)
    begin
      if (cif.set)
        cnt_q[cif.sel] <= cif.val; // R9
      else if (cif.inc)
        cnt_q[cif.sel] <= cnt_q[cif.sel] + 32'h0000_0001; // R8
    end
  end

  always_comb
  begin
    for (int i = 0; i < hcs_pkg::N_CNT; i++)
      cif.cnt[i] = cnt_q[i];
  end

  cnt_inc_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R8
    (ce_i && cif.inc && !cif.set) |=> cnt_q[$past(cif.sel)] == $past(cnt_q[cif.sel]) + 1)
    else $error("counter did not advance by one");
  cnt_set_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R9
    (ce_i && cif.set) |=> cnt_q[$past(cif.sel)] == $past(cif.val))
    else $error("counter did not take set value");
endmodule // hcs_counters
`default_nettype wire

/* verilog/hcs_scripter.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// (R1) At most sixteen entries; writes to an index of sixteen or more are refused.
// (R2) Every entry holds exactly one action; entries may share one condition.
// (R3) A condition is the AND of all its selected sub-condition sources.
// (R4) Init-class actions run only from entries triggered by the pre-init pulse.
// (R5) Role action picks access point, station, peer-to-peer or tag.
// (R6) Hardware indication routes an internal signal straight onto a pin.
// (R7) Runtime actions: packet sends, counters, timers, GPIO set, hibernate.
// (R8) Increment adds exactly one to the chosen user counter.
// (R9) Set loads a given value into the chosen user counter.
// (R10) Eight user counters and eight timers, no more.
// (R11) Timers count in whole one-second steps.
// (R12) User counters are thirty-two bits wide.
// (R13) Packet payload at most one packet, at most eight tokens.
// (R14) Set-GPIO drives a pin level from the engine.
// (R15) Host assumes no fixed latency from condition to action.
// (R16) Pending actions run one per cycle in ascending entry order.
module hcs_scripter #(
  parameter int SEC_CYCLES = hcs_pkg::TICK_CYC // cycles per one-second timer step
) (
  input wire logic mclk_i, // module clock, 20 MHz
  input wire logic reset_i, // sync reset, active high
  input wire logic ce_i, // clock enable, freezes all state when low
  input wire logic cfg_we_i, // entry write strobe
  input wire logic [hcs_pkg::CFG_IDX_W-1:0] cfg_idx_i, // entry index
  input wire logic cfg_preinit_i, // entry triggers on pre-init
  input wire logic [hcs_pkg::SRC_W-1:0] cfg_mask_i, // sub-condition select
  input wire hcs_pkg::hcs_act_t cfg_act_i, // action code
  input wire logic [hcs_pkg::SEL_W-1:0] cfg_arg_i, // counter, timer or pin select
  input wire logic [hcs_pkg::CNT_W-1:0] cfg_val_i, // action value
  output logic cfg_err_o, // write refused, one-cycle pulse
  input wire logic init_i, // pre-init condition pulse
  input wire logic [hcs_pkg::N_EVT-1:0] evt_i, // runtime event levels
  input wire logic [hcs_pkg::N_PIN-1:0] hw_sig_i, // internal core signals
  input wire logic [hcs_pkg::SEL_W-1:0] cnt_sel_i, // counter to view
  output logic [hcs_pkg::CNT_W-1:0] cnt_val_o, // viewed counter value
  output hcs_pkg::hcs_role_t role_o, // operating role
  output logic del_prof_o, // delete profiles pulse
  output logic [hcs_pkg::POL_W-1:0] policy_o, // connection policy
  output logic [hcs_pkg::N_PIN-1:0] gpio_o, // pin levels
  output logic pkt_req_o, // packet send pulse
  output hcs_pkg::hcs_pkt_t pkt_kind_o, // packet type
  output logic [hcs_pkg::IDX_W-1:0] pkt_id_o, // template (entry) index
  output logic [hcs_pkg::LEN_W-1:0] pkt_len_o, // payload length
  output logic [hcs_pkg::TOK_W-1:0] pkt_tok_o, // token count
  output logic [hcs_pkg::N_TMR-1:0] tmr_exp_o, // timer expired flags
  output logic hibernate_o // hibernate request level
);
  localparam int N = hcs_pkg::N_ENT;
  logic vld_q [N];
  logic pre_q [N];
  logic [hcs_pkg::SRC_W-1:0] mask_q [N];
  hcs_pkg::hcs_act_t act_q [N];
  logic [hcs_pkg::SEL_W-1:0] arg_q [N];
  logic [hcs_pkg::CNT_W-1:0] val_q [N];
  logic [N-1:0] cond_now, cond_prev_q, pend_q, pend_set, pend_clr;
  logic [hcs_pkg::SRC_W-1:0] src;
  logic fire;
  logic [hcs_pkg::IDX_W-1:0] fire_idx;
  hcs_pkg::hcs_act_t fa;
  logic init_ok, pkt_act, cfg_bad;
  logic [31:0] tick_q;
  logic tick;
  logic [hcs_pkg::TMR_W-1:0] tmr_q [hcs_pkg::N_TMR];
  logic [hcs_pkg::N_TMR-1:0] run_q, exp_q;
  logic [hcs_pkg::N_PIN-1:0] lvl_q, ind_q;
  hcs_cnt_if cif ();
  hcs_counters u_cnt (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .cif(cif)
  );
  // packet limits are checked once at write time so the send path stays simple
  assign pkt_act = cfg_act_i inside {hcs_pkg::ACT_SEND_TRX, hcs_pkg::ACT_SEND_UDP,
                                     hcs_pkg::ACT_SEND_TCP};
  assign cfg_bad = (cfg_idx_i >= 5'(N)) // R1
    || (pkt_act && (cfg_val_i[hcs_pkg::LEN_LSB +: hcs_pkg::LEN_W] > hcs_pkg::MAX_PKT_LEN
    || cfg_val_i[hcs_pkg::TOK_LSB +: hcs_pkg::TOK_W] > hcs_pkg::MAX_TOKENS)); // R13
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      cfg_err_o <= 1'b0;
      for (int i = 0; i < N; i++)
      begin
        vld_q[i] <= 1'b0;
        pre_q[i] <= 1'b0;
        mask_q[i] <= hcs_pkg::MASK_NONE;
        act_q[i] <= hcs_pkg::ACT_NOP;
        arg_q[i] <= '0;
        val_q[i] <= '0;
      end
    end
    else if (ce_i)
    begin
      cfg_err_o <= cfg_we_i && cfg_bad;
      if (cfg_we_i && !cfg_bad)
      begin
        vld_q[cfg_idx_i[hcs_pkg::IDX_W-1:0]] <= 1'b1;
        pre_q[cfg_idx_i[hcs_pkg::IDX_W-1:0]] <= cfg_preinit_i;
        mask_q[cfg_idx_i[hcs_pkg::IDX_W-1:0]] <= cfg_mask_i;
        act_q[cfg_idx_i[hcs_pkg::IDX_W-1:0]] <= cfg_act_i; // R2
        arg_q[cfg_idx_i[hcs_pkg::IDX_W-1:0]] <= cfg_arg_i;
        val_q[cfg_idx_i[hcs_pkg::IDX_W-1:0]] <= cfg_val_i;
      end
    end
  end
  assign src = {exp_q, evt_i};
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      cond_now[i] = vld_q[i] && !pre_q[i] && (mask_q[i] != hcs_pkg::MASK_NONE)
        && ((src & mask_q[i]) == mask_q[i]); // R3
      pend_set[i] = pre_q[i] ? (vld_q[i] && init_i) // R4
                             : (cond_now[i] && !cond_prev_q[i]); // R2
    end
  end
  // lowest pending entry wins; the others wait their turn
  always_comb
  begin
    fire = 1'b0;
    fire_idx = '0;
    pend_clr = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (pend_q[i])
      begin
        fire = 1'b1; // R16
        fire_idx = hcs_pkg::IDX_W'(i);
      end
    end
    if (fire)
      pend_clr[fire_idx] = 1'b1;
  end
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      cond_prev_q <= '0;
      pend_q <= '0;
    end
    else if (ce_i)
    begin
      cond_prev_q <= cond_now;
      pend_q <= (pend_q & ~pend_clr) | pend_set; // a new trigger beats the clear
    end
  end
  assign fa = act_q[fire_idx];
  assign init_ok = pre_q[fire_idx]; // R4
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      role_o <= hcs_pkg::ROLE_STATION;
      del_prof_o <= 1'b0;
      policy_o <= '0;
      ind_q <= '0;
      lvl_q <= '0;
      pkt_req_o <= 1'b0;
      pkt_kind_o <= hcs_pkg::PKT_TRX;
      pkt_id_o <= '0;
      pkt_len_o <= '0;
      pkt_tok_o <= '0;
      hibernate_o <= 1'b0;
    end
    else if (ce_i)
    begin
      del_prof_o <= 1'b0;
      pkt_req_o <= 1'b0;
      if (fire)
      begin
        case (fa)
          hcs_pkg::ACT_SET_ROLE:
            if (init_ok)
              role_o <= hcs_pkg::hcs_role_t'(val_q[fire_idx][1:0]); // R5
          hcs_pkg::ACT_DEL_PROFILES:
            del_prof_o <= init_ok; // R4
          hcs_pkg::ACT_SET_POLICY:
            if (init_ok)
              policy_o <= val_q[fire_idx][hcs_pkg::POL_W-1:0];
          hcs_pkg::ACT_HW_IND:
            if (init_ok)
              ind_q[arg_q[fire_idx]] <= 1'b1; // R6
          hcs_pkg::ACT_SEND_TRX, hcs_pkg::ACT_SEND_UDP, hcs_pkg::ACT_SEND_TCP:
          begin
            pkt_req_o <= 1'b1; // R7
            pkt_kind_o <= (fa == hcs_pkg::ACT_SEND_UDP) ? hcs_pkg::PKT_UDP
                        : (fa == hcs_pkg::ACT_SEND_TCP) ? hcs_pkg::PKT_TCP : hcs_pkg::PKT_TRX;
            pkt_id_o <= fire_idx;
            pkt_len_o <= val_q[fire_idx][hcs_pkg::LEN_LSB +: hcs_pkg::LEN_W]; // R13
            pkt_tok_o <= val_q[fire_idx][hcs_pkg::TOK_LSB +: hcs_pkg::TOK_W];
          end
          hcs_pkg::ACT_SET_GPIO:
            lvl_q[arg_q[fire_idx]] <= val_q[fire_idx][0]; // R14
          hcs_pkg::ACT_HIBERNATE:
            hibernate_o <= 1'b1; // R7
          default: ;
        endcase
      end
    end
  end
  // indicated pins follow the core signal one cycle later through one flop, no software path
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      gpio_o <= '0;
    else if (ce_i)
      gpio_o <= (ind_q & hw_sig_i) | (~ind_q & lvl_q); // R6 R14
  end
  assign cif.inc = fire && (fa == hcs_pkg::ACT_CNT_INC); // R8
  assign cif.set = fire && (fa == hcs_pkg::ACT_CNT_SET); // R9
  assign cif.sel = arg_q[fire_idx]; // R10
  assign cif.val = val_q[fire_idx]; // R12
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      cnt_val_o <= hcs_pkg::CNT_RST;
    else if (ce_i)
      cnt_val_o <= cif.cnt[cnt_sel_i];
  end
  assign tick = (tick_q == 32'(SEC_CYCLES - 1));
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      tick_q <= '0;
    else if (ce_i)
      tick_q <= tick ? '0 : tick_q + 32'h0000_0001; // R11
  end
  // a timer value of zero stops it; otherwise it reloads and expires on the that-many-th free-running second tick after the load
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      run_q <= '0;
      exp_q <= '0;
      for (int t = 0; t < hcs_pkg::N_TMR; t++)
        tmr_q[t] <= hcs_pkg::TMR_ZERO;
    end
    else if (ce_i)
    begin
      for (int t = 0; t < hcs_pkg::N_TMR; t++)
      begin
        if (fire && fa == hcs_pkg::ACT_TMR_CTRL && arg_q[fire_idx] == hcs_pkg::SEL_W'(t))
        begin
          tmr_q[t] <= val_q[fire_idx][hcs_pkg::TMR_W-1:0];
          run_q[t] <= (val_q[fire_idx][hcs_pkg::TMR_W-1:0] != hcs_pkg::TMR_ZERO);
          exp_q[t] <= run_q[t] && tick && (tmr_q[t] == hcs_pkg::TMR_ONE); // expiry wins
        end
        else if (run_q[t] && tick)
        begin
          tmr_q[t] <= tmr_q[t] - hcs_pkg::TMR_ONE; // R11
          if (tmr_q[t] == hcs_pkg::TMR_ONE)
          begin
            run_q[t] <= 1'b0;
            exp_q[t] <= 1'b1;
          end
        end
      end
    end
  end
  assign tmr_exp_o = exp_q;
  cfg_range_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R1
    (ce_i && cfg_we_i && cfg_idx_i >= 5'(N)) |=> cfg_err_o)
    else $error("out-of-range entry write not refused");
  and_cond_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R3
    (ce_i && vld_q[2] && !pre_q[2] && (src & mask_q[2]) != mask_q[2]) |=> !$rose(pend_q[2]))
    else $error("condition true without all sub-conditions");
  init_only_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R4
    (ce_i && fire && fa == hcs_pkg::ACT_DEL_PROFILES && !pre_q[fire_idx]) |=> !del_prof_o)
    else $error("init action ran at runtime");
  order_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R16
    fire |-> (pend_q & ((16'h0001 << fire_idx) - 16'h0001)) == 16'h0000)
    else $error("entry ran before a lower pending one");
  hw_ind_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R6
    ce_i |=> ((gpio_o ^ $past(hw_sig_i)) & $past(ind_q)) == '0)
    else $error("indicated pin does not follow core signal");
  pkt_limit_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R13
    pkt_req_o |-> pkt_tok_o <= hcs_pkg::MAX_TOKENS && pkt_len_o <= hcs_pkg::MAX_PKT_LEN)
    else $error("packet exceeds limits");
  pkt_pulse_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R7
    (ce_i && fire && fa == hcs_pkg::ACT_SEND_UDP) |=> pkt_req_o && pkt_kind_o == hcs_pkg::PKT_UDP)
    else $error("udp send not issued");
  tmr_step_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R11
    (ce_i && !tick && !fire) |=> $stable(tmr_q[0]))
    else $error("timer moved between second ticks");
  set_gpio_a: assert property (@(posedge mclk_i) disable iff (reset_i) // R14
    (ce_i && fire && fa == hcs_pkg::ACT_SET_GPIO && !ind_q[arg_q[fire_idx]]) ##1 ce_i
    |=> gpio_o[$past(arg_q[fire_idx], 2)] == $past(val_q[fire_idx][0], 2))
    else $error("gpio level not applied");
  multi_fire_c: cover property (@(posedge mclk_i) disable iff (reset_i) $countones(pend_q) > 1);
  tmr_exp_c: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(exp_q[0]));
  init_role_c: cover property (@(posedge mclk_i) disable iff (reset_i)
    fire && fa == hcs_pkg::ACT_SET_ROLE && init_ok);
  hib_c: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(hibernate_o));
endmodule // hcs_scripter
`default_nettype wire

/* test/hcs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// host side that loads script entries; between writes the fields carry the
// inverse of the last value so that a design reading them while idle is caught
module hcs_host_model (
  input wire logic mclk_i, // module clock
  output var logic cfg_we_o, // entry write strobe
  output var logic [hcs_pkg::CFG_IDX_W-1:0] cfg_idx_o, // entry index
  output var logic cfg_preinit_o, // pre-init trigger
  output var logic [hcs_pkg::SRC_W-1:0] cfg_mask_o, // sub-condition select
  output var hcs_pkg::hcs_act_t cfg_act_o, // action code
  output var logic [hcs_pkg::SEL_W-1:0] cfg_arg_o, // counter, timer or pin select
  output var logic [hcs_pkg::CNT_W-1:0] cfg_val_o // action value
);
  initial
  begin
    cfg_we_o = 1'b0;
    cfg_idx_o = 5'h00;
    cfg_preinit_o = 1'b0;
    cfg_mask_o = 16'h0000;
    cfg_act_o = hcs_pkg::ACT_NOP;
    cfg_arg_o = 3'h0;
    cfg_val_o = 32'h0000_0000;
  end

  task automatic write(input logic [4:0] idx, input logic pre, input logic [15:0] mask,
    input hcs_pkg::hcs_act_t act, input logic [2:0] arg, input logic [31:0] val);
    @(posedge mclk_i);
    cfg_we_o <= 1'b1;
    cfg_idx_o <= idx;
    cfg_preinit_o <= pre;
    cfg_mask_o <= mask;
    cfg_act_o <= act;
    cfg_arg_o <= arg;
    cfg_val_o <= val;
    @(posedge mclk_i);
    cfg_we_o <= 1'b0;
    cfg_idx_o <= ~idx;
    cfg_preinit_o <= ~pre;
    cfg_mask_o <= ~mask;
    cfg_act_o <= hcs_pkg::hcs_act_t'(~act);
    cfg_arg_o <= ~arg;
    cfg_val_o <= ~val;
  endtask
endmodule // hcs_host_model
`default_nettype wire

/* test/test_hcs_scripter.sv */
`timescale 1ns/1ps
`default_nettype none
module test_hcs_scripter;
  logic mclk_i = 1'b0;
  logic reset_i, ce_i, init_i, cfg_we, cfg_pre, cfg_err_o, del_prof_o, pkt_req_o, hibernate_o;
  logic [7:0] evt_i, hw_sig_i, policy_o, gpio_o, tmr_exp_o;
  logic [2:0] cnt_sel_i, cfg_arg;
  logic [4:0] cfg_idx;
  logic [15:0] cfg_mask;
  hcs_pkg::hcs_act_t cfg_act;
  logic [31:0] cfg_val, cnt_val_o, cv, pol, seen_v;
  hcs_pkg::hcs_role_t role_o;
  hcs_pkg::hcs_pkt_t pkt_kind_o;
  logic [3:0] pkt_id_o, pkt_tok_o, tok3;
  logic [10:0] pkt_len_o, len3;
  logic [21:0] note_q[$];
  int fail_count = 0;
  int n_tests = 0;
  int del_n = 0;
  int cyc = 0;
  int seed;

  always #25 mclk_i = ~mclk_i;

  hcs_host_model hcs_host_model_i (.mclk_i, .cfg_we_o(cfg_we), .cfg_idx_o(cfg_idx),
    .cfg_preinit_o(cfg_pre), .cfg_mask_o(cfg_mask), .cfg_act_o(cfg_act),
    .cfg_arg_o(cfg_arg), .cfg_val_o(cfg_val));

  // short second so timer expiry is reached in a few cycles
  hcs_scripter #(.SEC_CYCLES(5)) hcs_scripter_i (.mclk_i, .reset_i, .ce_i,
    .cfg_we_i(cfg_we), .cfg_idx_i(cfg_idx), .cfg_preinit_i(cfg_pre), .cfg_mask_i(cfg_mask),
    .cfg_act_i(cfg_act), .cfg_arg_i(cfg_arg), .cfg_val_i(cfg_val), .cfg_err_o, .init_i,
    .evt_i, .hw_sig_i, .cnt_sel_i, .cnt_val_o, .role_o, .del_prof_o, .policy_o, .gpio_o,
    .pkt_req_o, .pkt_kind_o, .pkt_id_o, .pkt_len_o, .pkt_tok_o, .tmr_exp_o, .hibernate_o);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic complete_run;
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cfg(input logic [4:0] idx, input logic pre, input logic [15:0] mask,
    input hcs_pkg::hcs_act_t act, input logic [2:0] arg, input logic [31:0] val,
    input logic bad);
    if (bad)
      note_q.push_back(22'h20_0000);
    hcs_host_model_i.write(idx, pre, mask, act, arg, val);
  endtask

  function automatic logic [21:0] pk(hcs_pkg::hcs_pkt_t k, logic [3:0] id, logic [10:0] ln,
    logic [3:0] tk);
    return {1'b0, k, id, ln, tk};
  endfunction

  // the host waits for results without assuming a latency
  task automatic drain;
    for (int i = 0; i < 40 && note_q.size() != 0; i++)
      @(posedge mclk_i);
    check("pending results", 32'(note_q.size()), 32'h0);
  endtask

  task automatic rise(input int b);
    @(posedge mclk_i);
    evt_i[b] <= 1'b1;
  endtask

  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fail_count++;
      complete_run();
    end
    if (reset_i === 1'b0 && del_prof_o === 1'b1)
      del_n++;
    if (reset_i === 1'b0 && (pkt_req_o === 1'b1 || cfg_err_o === 1'b1))
    begin
      seen_v = 32'({1'b0, pkt_kind_o, pkt_id_o, pkt_len_o, pkt_tok_o});
      if (cfg_err_o === 1'b1)
        seen_v = 32'h0020_0000;
      if (note_q.size() == 0)
        check("unexpected result", seen_v, 32'hFFFF_FFFF);
      else
        check("result", seen_v, 32'(note_q.pop_front()));
    end
  end

  initial
  begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    init_i = 1'b0;
    evt_i = 8'h00;
    hw_sig_i = 8'h00;
    cnt_sel_i = 3'h7;
    seed = $urandom(32'h8E3B);
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    check("reset outputs", 32'({role_o, policy_o, gpio_o, tmr_exp_o, hibernate_o, pkt_req_o}),
      32'h0);
    // index 16 must not alias onto entry 0, which would send an extra packet
    cfg(5'h10, 1'b0, 16'h0001, hcs_pkg::ACT_SEND_UDP, 3'h0, 32'h1, 1'b1);
    cfg(5'h1F, 1'b0, 16'h0001, hcs_pkg::ACT_SEND_UDP, 3'h0, 32'h1, 1'b1);
    cfg(5'h02, 1'b0, 16'h0003, hcs_pkg::ACT_SEND_TRX, 3'h0, 32'h0000_05C1, 1'b1);
    cfg(5'h02, 1'b0, 16'h0003, hcs_pkg::ACT_SEND_TRX, 3'h0, 32'h0000_9005, 1'b1);
    cfg(5'h02, 1'b0, 16'h0003, hcs_pkg::ACT_SEND_TRX, 3'h0, 32'h0000_85C0, 1'b0);
    len3 = 11'($urandom_range(1472, 0));
    tok3 = 4'($urandom_range(8, 0));
    cfg(5'h03, 1'b0, 16'h0001, hcs_pkg::ACT_SEND_UDP, 3'h0, {16'h0, tok3, 1'b0, len3}, 1'b0);
    cfg(5'h05, 1'b0, 16'h0001, hcs_pkg::ACT_SEND_TCP, 3'h0, 32'h0000_1001, 1'b0);
    drain();
    note_q.push_back(pk(hcs_pkg::PKT_UDP, 4'h3, len3, tok3));
    note_q.push_back(pk(hcs_pkg::PKT_TCP, 4'h5, 11'h001, 4'h1));
    rise(0);
    drain();
    note_q.push_back(pk(hcs_pkg::PKT_TRX, 4'h2, 11'h5C0, 4'h8));
    rise(1);
    drain();
    cv = $urandom() | 32'h8000_0000;
    cfg(5'h07, 1'b0, 16'h0008, hcs_pkg::ACT_CNT_SET, 3'h7, cv, 1'b0);
    cfg(5'h06, 1'b0, 16'h0004, hcs_pkg::ACT_CNT_INC, 3'h7, 32'h0, 1'b0);
    rise(3);
    repeat (10) @(posedge mclk_i);
    check("counter set", cnt_val_o, cv);
    rise(2);
    repeat (10) @(posedge mclk_i);
    check("counter inc", cnt_val_o, cv + 32'h1);
    // a low enable must hold the view register although the select moves
    ce_i <= 1'b0;
    cnt_sel_i <= 3'h0;
    repeat (3) @(posedge mclk_i);
    check("frozen view", cnt_val_o, cv + 32'h1);
    ce_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check("other counter", cnt_val_o, 32'h0);
    pol = 32'($urandom_range(255, 0));
    cfg(5'h04, 1'b0, 16'h0010, hcs_pkg::ACT_DEL_PROFILES, 3'h0, 32'h0, 1'b0);
    cfg(5'h08, 1'b0, 16'h0010, hcs_pkg::ACT_SET_ROLE, 3'h0, 32'h3, 1'b0);
    rise(4);
    repeat (10) @(posedge mclk_i);
    check("role at runtime", 32'(role_o), 32'h0);
    check("runtime delete", 32'(del_n), 32'h0);
    cfg(5'h0A, 1'b1, 16'h0, hcs_pkg::ACT_SET_POLICY, 3'h0, pol, 1'b0);
    cfg(5'h0B, 1'b1, 16'h0, hcs_pkg::ACT_DEL_PROFILES, 3'h0, 32'h0, 1'b0);
    cfg(5'h0C, 1'b1, 16'h0, hcs_pkg::ACT_HW_IND, 3'h5, 32'h0, 1'b0);
    for (int r = 0; r < 4; r++)
    begin
      cfg(5'h09, 1'b1, 16'h0, hcs_pkg::ACT_SET_ROLE, 3'h0, 32'(r), 1'b0);
      @(posedge mclk_i);
      init_i <= 1'b1;
      @(posedge mclk_i);
      init_i <= 1'b0;
      repeat (12) @(posedge mclk_i);
      check("role", 32'(role_o), 32'(r));
    end
    check("policy", 32'(policy_o), pol);
    check("profile deletes", 32'(del_n), 32'h4);
    hw_sig_i <= 8'h20;
    repeat (3) @(posedge mclk_i);
    check("hw pin high", 32'(gpio_o[5]), 32'h1);
    hw_sig_i <= 8'hDF;
    repeat (3) @(posedge mclk_i);
    check("hw pin low", 32'(gpio_o[5]), 32'h0);
    cfg(5'h0D, 1'b0, 16'h0020, hcs_pkg::ACT_SET_GPIO, 3'h2, 32'h1, 1'b0);
    rise(5);
    repeat (10) @(posedge mclk_i);
    check("gpio set", 32'(gpio_o[2]), 32'h1);
    cfg(5'h0E, 1'b0, 16'h0040, hcs_pkg::ACT_TMR_CTRL, 3'h0, 32'h2, 1'b0);
    cfg(5'h0F, 1'b0, 16'h0100, hcs_pkg::ACT_HIBERNATE, 3'h0, 32'h0, 1'b0);
    rise(6);
    repeat (4) @(posedge mclk_i);
    check("timer early", 32'({tmr_exp_o[0], hibernate_o}), 32'h0);
    for (int i = 0; i < 20 && tmr_exp_o[0] !== 1'b1; i++)
      @(posedge mclk_i);
    check("timer expiry", 32'(tmr_exp_o[0]), 32'h1);
    repeat (10) @(posedge mclk_i);
    check("hibernate", 32'(hibernate_o), 32'h1);
    // a zero load stops timer 0 and clears its flag; hibernate stays set
    cfg(5'h01, 1'b0, 16'h0080, hcs_pkg::ACT_TMR_CTRL, 3'h0, 32'h0, 1'b0);
    rise(7);
    repeat (10) @(posedge mclk_i);
    check("timer stopped", 32'({tmr_exp_o[0], hibernate_o}), 32'h1);
    drain();
    complete_run();
  end
endmodule // test_hcs_scripter
`default_nettype wire
